// File: verilog/lane_xbar_pkg.sv
// Package: register offsets, field positions and reset values of the lane status block
package lane_xbar_pkg;
	localparam int          LANES          = 8;
	localparam int          SEL_W          = 3;
	localparam int          DATA_W         = 8;
	// One register per 32-bit word, so byte address = 4 * index
	localparam logic [11:0] IDX_FULL       = 12'h30C;
	localparam logic [11:0] IDX_EMPTY      = 12'h30D;
	localparam logic [11:0] IDX_SYNC_MASK  = 12'h311;
	localparam logic [11:0] IDX_LANE6_SRC  = 12'h30E;
	localparam logic [11:0] IDX_IRQ_STAT   = 12'h320;
	localparam logic [11:0] IDX_IRQ_MASK   = 12'h321;
	localparam int          ADDR_W         = 14;
	localparam int          BIT_FRAME_EN   = 0;
	localparam int          BIT_MF_EN      = 2;
	localparam logic [7:0]  SYNC_MASK_WMSK = 8'h05;
	localparam logic [2:0]  LANE6_SRC_RST  = 3'h6;
	localparam logic [7:0]  ZERO8          = 8'h00;
	// Interrupt status bits
	localparam int          IRQ_FRAME_LOSS = 0;
	localparam int          IRQ_MF_LOSS    = 1;
	localparam int          IRQ_ANY_FULL   = 2;
	localparam int          IRQ_W          = 3;
	localparam logic [2:0]  IRQ_RST        = 3'h0;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
		byte_addr = {idx, 2'h0};
	endfunction
endpackage

// File: verilog/flag_sync.sv
// Two-flop synchroniser for a vector of asynchronous status levels
`timescale 1ns/10ps
`default_nettype none
module flag_sync (
	input  wire logic                            clk_i,  // System clock
	input  wire logic                            rst_i,  // Synchronous reset
	input  wire logic                            ce_i,   // Clock enable
	input  wire logic [lane_xbar_pkg::DATA_W-1:0] d_i,    // Asynchronous levels
	output logic      [lane_xbar_pkg::DATA_W-1:0] q_o     // Synchronised levels
);
	import lane_xbar_pkg::*;
	logic [DATA_W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= ZERO8;
			q_o    <= ZERO8;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: verilog/lane_mux.sv
// Eight-way lane selector with registered output
`timescale 1ns/10ps
`default_nettype none
module lane_mux (
	input  wire logic                            clk_i,  // System clock
	input  wire logic                            rst_i,  // Synchronous reset
	input  wire logic                            ce_i,   // Clock enable
	input  wire logic [lane_xbar_pkg::SEL_W-1:0]  sel_i,  // Source pair index
	input  wire logic [lane_xbar_pkg::LANES-1:0]  pair_i, // Physical pair data bits
	output logic                                 lane_o  // Selected lane bit
);
	import lane_xbar_pkg::*;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lane_o <= 1'b0;
		end else if (ce_i) begin
			lane_o <= pair_i[sel_i];
		end
	end
endmodule
`default_nettype wire

// File: verilog/lane_crossbar_fifo_sync_status.sv
// Lane 6 crossbar entry, FIFO status flags and sync request masking over Wishbone
// Overview of operation
// - Logical lane 6 carries the pair picked by the 3-bit select; reset picks 6.
// - Read-only full vector, bit n for pair n FIFO, resets zero.
// - Read-only empty vector, bit n for pair n FIFO, resets zero.
// - Mask bit 2 set lets multiframe loss raise sync request; resets 0.
// - Mask bit 0 set lets frame loss raise sync request; clear blocks it.
`timescale 1ns/10ps
`default_nettype none
module lane_crossbar_fifo_sync_status (
	input  wire logic                             clk_i,          // 125 MHz clock
	input  wire logic                             rst_i,          // Synchronous reset, active high
	input  wire logic                             ce_i,           // Clock enable, freezes state when low
	input  wire logic                             cyc_i,          // Wishbone cycle
	input  wire logic                             stb_i,          // Wishbone strobe
	input  wire logic                             we_i,           // Wishbone write enable
	input  wire logic [lane_xbar_pkg::ADDR_W-1:0]  adr_i,          // Wishbone byte address
	input  wire logic [3:0]                       sel_i,          // Wishbone byte selects
	input  wire logic [31:0]                      dat_i,          // Wishbone write data
	output logic      [31:0]                      dat_o,          // Wishbone read data
	output logic                                  ack_o,          // Wishbone acknowledge
	output logic                                  err_o,          // Wishbone error, unmapped address
	input  wire logic [lane_xbar_pkg::LANES-1:0]   serial_pair_i,  // Recovered bits of pairs 0..7
	output logic                                  logical_lane6_o,// Lane 6 data bit
	input  wire logic [lane_xbar_pkg::LANES-1:0]   fifo_full_i,    // Per-pair FIFO full, async
	input  wire logic [lane_xbar_pkg::LANES-1:0]   fifo_empty_i,   // Per-pair FIFO empty, async
	input  wire logic                             frame_loss_i,   // Deframer zero loss of frame
	input  wire logic                             mf_loss_i,      // Deframer zero loss of multiframe
	output logic                                  sync_request_out_o, // Sync request, active high
	output logic                                  irq_o           // Level interrupt
);
	import lane_xbar_pkg::*;

	logic [SEL_W-1:0]  logical_lane6_source_r;
	logic [7:0]        sync_loss_mask_r;
	logic [IRQ_W-1:0]  irq_stat_r;
	logic [IRQ_W-1:0]  irq_mask_r;
	logic [IRQ_W-1:0]  irq_evt;
	logic [DATA_W-1:0] full_s;
	logic [DATA_W-1:0] empty_s;
	logic [1:0]        loss_meta_r;
	logic [1:0]        loss_s_r;
	logic              req;
	logic              wr;
	logic              rd_hit;
	logic [31:0]       rd_nxt;
	logic [DATA_W-1:0] full_prev_r;

	flag_sync u_full_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (fifo_full_i),
		.q_o   (full_s)
	);

	flag_sync u_empty_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (fifo_empty_i),
		.q_o   (empty_s)
	);

	lane_mux u_lane6 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.sel_i  (logical_lane6_source_r),
		.pair_i (serial_pair_i),
		.lane_o (logical_lane6_o)
	);

	// Deframer loss flags arrive from the link side; two flops each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loss_meta_r <= 2'h0;
			loss_s_r    <= 2'h0;
		end else if (ce_i) begin
			loss_meta_r <= {mf_loss_i, frame_loss_i};
			loss_s_r    <= loss_meta_r;
		end
	end

	// Bus decode; one access per ack, ack drops the cycle after it is given
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign wr  = req && we_i && sel_i[0];

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
		hit = (a == byte_addr(idx));
	endfunction

	always_comb begin
		rd_hit = 1'b1;
		rd_nxt = 32'h0000_0000;
		if (hit(adr_i, IDX_FULL)) begin
			rd_nxt[DATA_W-1:0] = full_s;
		end else if (hit(adr_i, IDX_EMPTY)) begin
			rd_nxt[DATA_W-1:0] = empty_s;
		end else if (hit(adr_i, IDX_SYNC_MASK)) begin
			rd_nxt[DATA_W-1:0] = sync_loss_mask_r;
		end else if (hit(adr_i, IDX_LANE6_SRC)) begin
			rd_nxt[SEL_W-1:0] = logical_lane6_source_r;
		end else if (hit(adr_i, IDX_IRQ_STAT)) begin
			rd_nxt[IRQ_W-1:0] = irq_stat_r;
		end else if (hit(adr_i, IDX_IRQ_MASK)) begin
			rd_nxt[IRQ_W-1:0] = irq_mask_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_o <= req && rd_hit;
			err_o <= req && !rd_hit;
			if (req && rd_hit && !we_i) begin
				dat_o <= rd_nxt;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			logical_lane6_source_r <= LANE6_SRC_RST;
		end else if (ce_i && wr && hit(adr_i, IDX_LANE6_SRC)) begin
			logical_lane6_source_r <= dat_i[SEL_W-1:0];
		end
	end

	// Reserved bits of the mask register stay zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_loss_mask_r <= ZERO8;
		end else if (ce_i && wr && hit(adr_i, IDX_SYNC_MASK)) begin
			sync_loss_mask_r <= dat_i[DATA_W-1:0] & SYNC_MASK_WMSK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_r <= IRQ_RST;
		end else if (ce_i && wr && hit(adr_i, IDX_IRQ_MASK)) begin
			irq_mask_r <= dat_i[IRQ_W-1:0];
		end
	end

	// Sync request is a registered level so it never glitches at the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_request_out_o <= 1'b0;
		end else if (ce_i) begin
			sync_request_out_o <= (sync_loss_mask_r[BIT_MF_EN] && loss_s_r[1])
				|| (sync_loss_mask_r[BIT_FRAME_EN] && loss_s_r[0]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_prev_r <= ZERO8;
		end else if (ce_i) begin
			full_prev_r <= full_s;
		end
	end

	always_comb begin
		irq_evt                 = IRQ_RST;
		irq_evt[IRQ_FRAME_LOSS] = loss_s_r[0];
		irq_evt[IRQ_MF_LOSS]    = loss_s_r[1];
		irq_evt[IRQ_ANY_FULL]   = |(full_s & ~full_prev_r);
	end

	// Write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= IRQ_RST;
		end else if (ce_i) begin
			if (wr && hit(adr_i, IDX_IRQ_STAT)) begin
				irq_stat_r <= (irq_stat_r & ~dat_i[IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_r <= irq_stat_r | irq_evt;
			end
		end
	end

	assign irq_o = |(irq_stat_r & irq_mask_r);

	// Sync request paths, one sequence per enable bit
	sequence s_mf_loss_enabled;
		ce_i && sync_loss_mask_r[BIT_MF_EN] && loss_s_r[1];
	endsequence

	sequence s_frame_loss_enabled;
		ce_i && sync_loss_mask_r[BIT_FRAME_EN] && loss_s_r[0];
	endsequence

	a_mf_enable_path: assert property (@(posedge clk_i) disable iff (rst_i)
		s_mf_loss_enabled |=> sync_request_out_o)
		else $error("multiframe loss did not raise sync request");

	a_mf_masked_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !sync_loss_mask_r[BIT_MF_EN] && !(sync_loss_mask_r[BIT_FRAME_EN] && loss_s_r[0]))
		|=> !sync_request_out_o)
		else $error("sync request raised with multiframe path masked");

	a_sync_masked_off: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !sync_loss_mask_r[BIT_FRAME_EN] && !(sync_loss_mask_r[BIT_MF_EN] && loss_s_r[1]))
		|=> !sync_request_out_o)
		else $error("sync request raised while masked");

	a_frame_enable_path: assert property (@(posedge clk_i) disable iff (rst_i)
		s_frame_loss_enabled |=> sync_request_out_o)
		else $error("frame loss did not raise sync request");

	a_sync_quiet_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !loss_s_r[0] && !loss_s_r[1]) |=> !sync_request_out_o)
		else $error("sync request raised with no loss present");

	a_sync_reset: assert property (@(posedge clk_i)
		rst_i |=> !sync_request_out_o)
		else $error("sync request not cleared by reset");

	// A frozen clock enable must hold the request where it stood
	a_sync_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(sync_request_out_o))
		else $error("sync request moved while clock enable low");

	a_mask_reset: assert property (@(posedge clk_i)
		rst_i |=> sync_loss_mask_r == ZERO8)
		else $error("sync mask reset value wrong");

	sequence s_wr_mask;
		ce_i && wr && hit(adr_i, IDX_SYNC_MASK);
	endsequence

	a_mask_mf_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_mask |=> sync_loss_mask_r[BIT_MF_EN] == $past(dat_i[BIT_MF_EN]))
		else $error("multiframe enable bit not written");

	a_mask_frame_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_mask |=> sync_loss_mask_r[BIT_FRAME_EN] == $past(dat_i[BIT_FRAME_EN]))
		else $error("frame enable bit not written");

	a_lane6_select: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i |=> logical_lane6_o == $past(serial_pair_i[logical_lane6_source_r]))
		else $error("lane 6 carries wrong pair");

	a_lane6_reset: assert property (@(posedge clk_i)
		rst_i |=> logical_lane6_source_r == LANE6_SRC_RST)
		else $error("lane 6 select reset value wrong");

	sequence s_wr_lane6;
		ce_i && wr && hit(adr_i, IDX_LANE6_SRC);
	endsequence

	a_lane6_write: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_lane6 |=> logical_lane6_source_r == $past(dat_i[SEL_W-1:0]))
		else $error("lane 6 select not written");

	a_lane6_out_reset: assert property (@(posedge clk_i)
		rst_i |=> !logical_lane6_o)
		else $error("lane 6 output not cleared by reset");

	a_lane6_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(logical_lane6_o))
		else $error("lane 6 output moved while clock enable low");

	sequence s_rd_full;
		ce_i && req && !we_i && hit(adr_i, IDX_FULL);
	endsequence

	sequence s_rd_empty;
		ce_i && req && !we_i && hit(adr_i, IDX_EMPTY);
	endsequence

	a_full_read_live: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_full |=> ack_o && dat_o == {24'h000000, $past(full_s)})
		else $error("full flag read mismatch");

	a_empty_read_live: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rd_empty |=> ack_o && dat_o == {24'h000000, $past(empty_s)})
		else $error("empty flag read mismatch");

	// Two flops of latency and nothing more: a read neither latches nor disturbs the flags
	a_flags_no_side: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_rd_full or s_rd_empty) ##1 ce_i
		|=> full_s == $past(fifo_full_i, 2) && empty_s == $past(fifo_empty_i, 2))
		else $error("flag read disturbed flag tracking");

	a_full_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i ##1 ce_i |=> full_s == $past(fifo_full_i, 2))
		else $error("full flags do not follow the FIFO state");

	a_empty_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i ##1 ce_i |=> empty_s == $past(fifo_empty_i, 2))
		else $error("empty flags do not follow the FIFO state");

	a_flags_reset: assert property (@(posedge clk_i)
		rst_i |=> full_s == ZERO8 && empty_s == ZERO8)
		else $error("flag vectors not cleared by reset");

	sequence s_take_hit;
		ce_i && req && rd_hit;
	endsequence

	a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		s_take_hit |=> ack_o && !err_o)
		else $error("mapped access not acknowledged");

	a_err_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && req && !rd_hit) |=> err_o && !ack_o)
		else $error("unmapped access not refused");

	// Registered ack must fall by itself, or the master would see a second transfer
	a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && ack_o) |=> !ack_o)
		else $error("ack held longer than one cycle");

	a_err_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && err_o) |=> !err_o)
		else $error("error held longer than one cycle");

	a_no_answer_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !(cyc_i && stb_i)) |=> !ack_o && !err_o)
		else $error("answer given without a request");

	a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		dat_o[31:DATA_W] == '0)
		else $error("read data upper bits not zero");

	a_bus_reset: assert property (@(posedge clk_i)
		rst_i |=> !ack_o && !err_o && dat_o == '0)
		else $error("bus outputs not cleared by reset");

	a_irq_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && !(wr && hit(adr_i, IDX_IRQ_STAT))) |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r))
		else $error("interrupt status bit lost without a clear");

	a_irq_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && irq_evt[IRQ_FRAME_LOSS]) |=> irq_stat_r[IRQ_FRAME_LOSS])
		else $error("frame loss event did not set status");

	a_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr && hit(adr_i, IDX_IRQ_STAT) && dat_i[IRQ_FRAME_LOSS] && !irq_evt[IRQ_FRAME_LOSS])
		|=> !irq_stat_r[IRQ_FRAME_LOSS])
		else $error("write of one did not clear status");

	a_irq_reset: assert property (@(posedge clk_i)
		rst_i |=> !irq_o)
		else $error("interrupt not cleared by reset");
endmodule
`default_nettype wire

// File: testbench/lane_far_end.sv
// Far-end transmitter stand-in that drives the recovered pair bits
`timescale 1ns/10ps
`default_nettype none
module lane_far_end (
	input  wire logic       clk_i,  // System clock
	input  wire logic       rst_i,  // Synchronous reset
	output var  logic [7:0] pair_o = 8'h96 // Pair bits, new pattern each cycle
);
	// Every bit moves often, so a wrong lane select cannot match for long
	always @(posedge clk_i) begin
		if (rst_i) begin
			pair_o <= 8'h96;
		end else begin
			pair_o <= {pair_o[6:0], ~pair_o[7]} ^ 8'h21;
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the lane status block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import lane_xbar_pkg::*;
	logic              clk_i        = 1'b0;
	logic              rst_i        = 1'b1;
	logic              ce_i         = 1'b1;
	logic              cyc_i        = 1'b0;
	logic              stb_i        = 1'b0;
	logic              we_i         = 1'b0;
	logic [ADDR_W-1:0] adr_i        = '0;
	logic [31:0]       dat_i        = '0;
	logic [7:0]        fifo_full_i  = 8'h00;
	logic [7:0]        fifo_empty_i = 8'h00;
	logic              frame_loss_i = 1'b0;
	logic              mf_loss_i    = 1'b0;
	logic [31:0]       dat_o;
	logic              ack_o;
	logic              err_o;
	logic [7:0]        serial_pair_i;
	logic              logical_lane6_o;
	logic              sync_request_out_o;
	logic              irq_o;
	int                n_mismatch   = 0;
	int                tests_run    = 0;
	logic [31:0]       rd;
	logic              er;
	logic [7:0]        pv;
	// Mask, frame loss, multiframe loss, expected request
	logic [5:0]        sc [5] = '{6'b000_11_0, 6'b001_10_1, 6'b001_01_0, 6'b100_01_1, 6'b100_10_0};

	lane_far_end u_lane_far_end (.clk_i, .rst_i, .pair_o(serial_pair_i));
	lane_crossbar_fifo_sync_status u_lane_crossbar_fifo_sync_status (
		.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF),
		.dat_i, .dat_o, .ack_o, .err_o, .serial_pair_i, .logical_lane6_o,
		.fifo_full_i, .fifo_empty_i, .frame_loss_i, .mf_loss_i, .sync_request_out_o, .irq_o);

	always #4 clk_i = ~clk_i;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Classic single cycle; the answer is sampled at the edge, before the slave updates
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd = dat_o;
		er = err_o;
		if (n >= 20) begin
			chk("bus answer", 32'h0, 32'h1);
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input string what);
		bus(1'b0, idx, 8'h00);
		chk(what, rd, exp);
	endtask

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(8 * 20000);
		n_mismatch++;
		conclude();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(IDX_LANE6_SRC, 32'h6, "lane6 select reset");
		rdc(IDX_SYNC_MASK, 32'h0, "sync mask reset");
		rdc(IDX_FULL, 32'h0, "full reset");
		rdc(IDX_EMPTY, 32'h0, "empty reset");
		bus(1'b0, 12'h300, 8'h00);
		chk("unmapped error", {31'h0, er}, 32'h1);
		bus(1'b1, IDX_IRQ_MASK, 8'h01);
		frame_loss_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("irq raised", {31'h0, irq_o}, 32'h1);
		bus(1'b1, IDX_IRQ_MASK, 8'h00);
		@(posedge clk_i);
		chk("irq masked", {31'h0, irq_o}, 32'h0);
		frame_loss_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		bus(1'b1, IDX_IRQ_STAT, 8'h07);
		rdc(IDX_IRQ_STAT, 32'h0, "irq cleared");
		foreach (sc[i]) begin
			bus(1'b1, IDX_SYNC_MASK, {5'h0, sc[i][5:3]});
			frame_loss_i <= sc[i][2];
			mf_loss_i    <= sc[i][1];
			repeat (6) @(posedge clk_i);
			chk("sync request", {31'h0, sync_request_out_o}, {31'h0, sc[i][0]});
		end
		bus(1'b1, IDX_SYNC_MASK, 8'hFF);
		rdc(IDX_SYNC_MASK, 32'h5, "sync mask readback");
		frame_loss_i <= 1'b0;
		mf_loss_i    <= 1'b0;
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, IDX_LANE6_SRC, 8'(s));
			rdc(IDX_LANE6_SRC, 32'(s), "lane6 select readback");
			repeat (3) begin
				@(posedge clk_i);
				pv = serial_pair_i;
				#1 chk("lane6 data", {31'h0, logical_lane6_o}, {31'h0, pv[s]});
			end
		end
		fifo_full_i  <= 8'hA5;
		fifo_empty_i <= 8'h3C;
		repeat (3) @(posedge clk_i);
		rdc(IDX_FULL, 32'hA5, "full flags");
		rdc(IDX_FULL, 32'hA5, "full flags reread");
		rdc(IDX_EMPTY, 32'h3C, "empty flags");
		fifo_full_i  <= 8'h5A;
		fifo_empty_i <= 8'hC3;
		repeat (3) @(posedge clk_i);
		bus(1'b1, IDX_FULL, 8'hFF);
		rdc(IDX_FULL, 32'h5A, "full flags live");
		rdc(IDX_EMPTY, 32'hC3, "empty flags live");
		rdc(IDX_IRQ_STAT, 32'h7, "irq status sticky");
		ce_i         <= 1'b0;
		frame_loss_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("sync frozen", {31'h0, sync_request_out_o}, 32'h0);
		ce_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("sync after enable", {31'h0, sync_request_out_o}, 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
